// ==== hw/mfid_defs.svh ====
// Constants for the multi-function input decoder
`ifndef MFID_DEFS_SVH
`define MFID_DEFS_SVH

// ---------------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------------
`define MFID_NUM_IN 8
`define MFID_CODE_W 8
`define MFID_VAL_W 16

// ---------------------------------------------------------------------
// Function codes and fields
// ---------------------------------------------------------------------
`define MFID_EXT_GROUP 4'h2
`define MFID_POL_BIT 0
`define MFID_RUNONLY_BIT 1
`define MFID_ACT_LSB 2
`define MFID_CODE_DC_INJ 8'h60
`define MFID_CODE_SRCH_MAX 8'h61
`define MFID_CODE_SRCH_REF 8'h62
`define MFID_CODE_TRQ_SEL 8'h71
`define MFID_CODE_ZERO_SERVO 8'h72
`define MFID_CODE_GAIN_TWO 8'h77

// ---------------------------------------------------------------------
// Thresholds and timing
// ---------------------------------------------------------------------
`define MFID_SRCH_CUR_LVL 16'h0400
`define MFID_CLK_MHZ 20
`define MFID_MIN_BB_US 500
`define MFID_MIN_BB_CYC (`MFID_MIN_BB_US * `MFID_CLK_MHZ)

`endif

// ==== hw/mfid_pkg.sv ====
// Types shared by the multi-function input decoder
package mfid_pkg;

    // -----------------------------------------------------------------
    // Stop actions of an external fault
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        MFID_ACT_DECEL,
        MFID_ACT_COAST,
        MFID_ACT_FAST,
        MFID_ACT_ALARM
    } mfid_act_e;

    typedef enum logic [1:0] {
        MFID_STOP_NONE,
        MFID_STOP_DECEL,
        MFID_STOP_COAST,
        MFID_STOP_FAST
    } mfid_stop_e;

    // -----------------------------------------------------------------
    // Speed search sequence
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        MFID_SS_IDLE,
        MFID_SS_BASEBLOCK,
        MFID_SS_LOWER,
        MFID_SS_ACCEL
    } mfid_ss_e;

    // Decoded external-fault assignment
    typedef struct packed {
        logic is_ext;
        logic norm_closed;
        logic run_only;
        mfid_act_e action;
    } mfid_ext_s;

    // Drive sequencer status entering the block
    typedef struct packed {
        logic running;
        logic run_cmd;
        logic jog_cmd;
        logic flux_vector;
        logic ref_reached;
    } mfid_drv_s;

    // Control requests leaving the block
    typedef struct packed {
        logic dc_brake;
        logic init_excite;
        logic torque_mode;
        logic zero_servo;
        logic gain_two;
    } mfid_ctl_s;

    // Speed search requests leaving the block
    typedef struct packed {
        logic baseblock;
        logic from_max;
        logic lower_freq;
        logic accel_ref;
    } mfid_srch_s;

endpackage : mfid_pkg

// ==== hw/mfid_top.sv ====
// Multi-function input decoder: faults, braking, search and mode selects
`include "mfid_defs.svh"

module mfid_top #(
    parameter int unsigned MIN_BB_CYCLES = `MFID_MIN_BB_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [`MFID_NUM_IN-1:0] MF_IN,
    input wire logic [`MFID_NUM_IN*`MFID_CODE_W-1:0] MF_FUNC,
    input wire mfid_pkg::mfid_drv_s DRV_STAT,
    input wire logic [`MFID_VAL_W-1:0] SPEED_REF,
    input wire logic [`MFID_VAL_W-1:0] ZERO_SPEED_LEVEL,
    input wire logic [`MFID_VAL_W-1:0] OUT_CURRENT,
    input wire logic FAULT_CLEAR,
    output logic FAULT,
    output logic ALARM,
    output mfid_pkg::mfid_stop_e STOP_MODE,
    output logic OUTPUT_CUTOFF,
    output mfid_pkg::mfid_ctl_s CTL,
    output mfid_pkg::mfid_srch_s SRCH
);
    import mfid_pkg::*;

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [`MFID_NUM_IN-1:0] sync1;
        logic [`MFID_NUM_IN-1:0] sync2;
        logic [`MFID_NUM_IN-1:0] sync3;
        logic [`MFID_NUM_IN-1:0] level;
        logic run_prev;
        logic fault;
        logic alarm;
        mfid_stop_e stop_mode;
        logic cutoff;
        mfid_ctl_s ctl;
        mfid_ss_e ss_state;
        logic [31:0] bb_cnt;
        mfid_srch_s srch;
    } mfid_state_s;

    mfid_state_s st_r;
    mfid_state_s st_nxt;

    // -----------------------------------------------------------------
    // Decoding helpers
    // -----------------------------------------------------------------
    function automatic logic [`MFID_CODE_W-1:0] code_of(
        input logic [`MFID_NUM_IN*`MFID_CODE_W-1:0] all,
        input int unsigned idx
    );
        code_of = all[idx*`MFID_CODE_W +: `MFID_CODE_W];
    endfunction : code_of

    function automatic mfid_ext_s ext_decode(
        input logic [`MFID_CODE_W-1:0] code
    );
        mfid_ext_s d;
        d.is_ext = (code[7:4] == `MFID_EXT_GROUP);
        d.norm_closed = code[`MFID_POL_BIT];
        d.run_only = code[`MFID_RUNONLY_BIT];
        d.action = mfid_act_e'(code[`MFID_ACT_LSB +: 2]);
        ext_decode = d;
    endfunction : ext_decode

    // True when any input assigned the given code is on
    function automatic logic func_on(
        input logic [`MFID_NUM_IN*`MFID_CODE_W-1:0] all,
        input logic [`MFID_NUM_IN-1:0] lvl,
        input logic [`MFID_CODE_W-1:0] code
    );
        logic hit;
        hit = 1'b0;
        for (int unsigned i = 0; i < `MFID_NUM_IN; i++) begin
            if (code_of(all, i) == code && lvl[i]) begin
                hit = 1'b1;
            end
        end
        func_on = hit;
    endfunction : func_on

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        mfid_ext_s ed;
        logic det_decel;
        logic det_coast;
        logic det_fast;
        logic det_alarm;
        logic detect;
        logic stopped;
        logic dc_on;
        logic srch_on;
        logic run_rise;

        ed = '0;
        det_decel = 1'b0;
        det_coast = 1'b0;
        det_fast = 1'b0;
        det_alarm = 1'b0;
        detect = 1'b0;
        stopped = 1'b0;
        dc_on = 1'b0;
        srch_on = 1'b0;
        run_rise = 1'b0;
        st_nxt = st_r;

        // Pins are asynchronous; a change is taken only once the second
        // and third stages agree, which also rejects single-cycle glitches
        st_nxt.sync1 = MF_IN;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        for (int unsigned i = 0; i < `MFID_NUM_IN; i++) begin
            if (st_r.sync2[i] == st_r.sync3[i]) begin
                st_nxt.level[i] = st_r.sync3[i];
            end
        end

        // External faults from the settled levels
        for (int unsigned i = 0; i < `MFID_NUM_IN; i++) begin
            ed = ext_decode(code_of(MF_FUNC, i));
            detect = ed.is_ext
                     && (st_r.level[i] ^ ed.norm_closed)
                     && (!ed.run_only || DRV_STAT.running);
            if (detect) begin
                unique case (ed.action)
                    MFID_ACT_DECEL: det_decel = 1'b1;
                    MFID_ACT_COAST: det_coast = 1'b1;
                    MFID_ACT_FAST: det_fast = 1'b1;
                    MFID_ACT_ALARM: det_alarm = 1'b1;
                endcase
            end
        end

        // Alarm follows the condition; the drive is left running
        st_nxt.alarm = det_alarm;

        // Fault is held until cleared; a new detection wins over a clear
        if (FAULT_CLEAR) begin
            st_nxt.fault = 1'b0;
            st_nxt.stop_mode = MFID_STOP_NONE;
            st_nxt.cutoff = 1'b0;
        end
        // Only one input may carry a fault code, so the severity order
        // below only matters for a misconfigured drive
        if (det_coast) begin
            st_nxt.fault = 1'b1;
            st_nxt.stop_mode = MFID_STOP_COAST;
            st_nxt.cutoff = 1'b1;
        end else if (det_fast) begin
            st_nxt.fault = 1'b1;
            if (st_nxt.stop_mode != MFID_STOP_COAST) begin
                st_nxt.stop_mode = MFID_STOP_FAST;
            end
        end else if (det_decel) begin
            st_nxt.fault = 1'b1;
            if (st_nxt.stop_mode == MFID_STOP_NONE) begin
                st_nxt.stop_mode = MFID_STOP_DECEL;
            end
        end

        // DC injection only while fully stopped; run or jog cancels it
        stopped = !DRV_STAT.running && !DRV_STAT.run_cmd
                  && !DRV_STAT.jog_cmd;
        dc_on = func_on(MF_FUNC, st_r.level, `MFID_CODE_DC_INJ) && stopped;
        st_nxt.ctl.dc_brake = dc_on && !DRV_STAT.flux_vector;
        st_nxt.ctl.init_excite = dc_on && DRV_STAT.flux_vector;

        // Control mode selects
        st_nxt.ctl.torque_mode =
            func_on(MF_FUNC, st_r.level, `MFID_CODE_TRQ_SEL);
        st_nxt.ctl.zero_servo =
            func_on(MF_FUNC, st_r.level, `MFID_CODE_ZERO_SERVO)
            && (SPEED_REF < ZERO_SPEED_LEVEL);
        // Only the proportional term moves; integral time is untouched
        st_nxt.ctl.gain_two =
            func_on(MF_FUNC, st_r.level, `MFID_CODE_GAIN_TWO);

        // Speed search sequence
        srch_on = func_on(MF_FUNC, st_r.level, `MFID_CODE_SRCH_MAX)
                  || func_on(MF_FUNC, st_r.level, `MFID_CODE_SRCH_REF);
        run_rise = DRV_STAT.run_cmd && !st_r.run_prev;
        st_nxt.run_prev = DRV_STAT.run_cmd;

        unique case (st_r.ss_state)
            MFID_SS_IDLE: begin
                if (srch_on && run_rise) begin
                    // Starting point chosen at the run edge
                    st_nxt.srch.from_max = func_on(MF_FUNC, st_r.level,
                        `MFID_CODE_SRCH_MAX);
                    st_nxt.srch.baseblock = 1'b1;
                    st_nxt.bb_cnt = '0;
                    st_nxt.ss_state = MFID_SS_BASEBLOCK;
                end
            end
            MFID_SS_BASEBLOCK: begin
                // Lets residual motor flux decay before voltage returns
                st_nxt.bb_cnt = st_r.bb_cnt + 32'h0000_0001;
                if (st_r.bb_cnt >= MIN_BB_CYCLES - 1) begin
                    st_nxt.srch.baseblock = 1'b0;
                    st_nxt.srch.lower_freq = 1'b1;
                    st_nxt.ss_state = MFID_SS_LOWER;
                end
            end
            MFID_SS_LOWER: begin
                if (OUT_CURRENT < `MFID_SRCH_CUR_LVL) begin
                    st_nxt.srch.lower_freq = 1'b0;
                    st_nxt.srch.accel_ref = 1'b1;
                    st_nxt.ss_state = MFID_SS_ACCEL;
                end
            end
            MFID_SS_ACCEL: begin
                if (DRV_STAT.ref_reached) begin
                    st_nxt.srch.accel_ref = 1'b0;
                    st_nxt.ss_state = MFID_SS_IDLE;
                end
            end
        endcase

        // Dropping the run command abandons a search in progress
        if (!DRV_STAT.run_cmd && st_r.ss_state != MFID_SS_IDLE) begin
            st_nxt.srch = '0;
            st_nxt.ss_state = MFID_SS_IDLE;
        end
        // A coast fault cuts the output, so no search may drive it
        if (st_nxt.cutoff) begin
            st_nxt.srch = '0;
            st_nxt.ss_state = MFID_SS_IDLE;
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Outputs, all straight from the state register
    // -----------------------------------------------------------------
    assign FAULT = st_r.fault;
    assign ALARM = st_r.alarm;
    assign STOP_MODE = st_r.stop_mode;
    assign OUTPUT_CUTOFF = st_r.cutoff;
    assign CTL = st_r.ctl;
    assign SRCH = st_r.srch;

endmodule : mfid_top

// ==== test/mfid_checker.sv ====
// Port assertions for the multi-function input decoder
`include "mfid_defs.svh"
module mfid_checker
    import mfid_pkg::*;
#(
    parameter int unsigned MIN_BB_CYCLES = 8
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] MF_IN,
    input wire logic [63:0] MF_FUNC,
    input wire mfid_pkg::mfid_drv_s DRV_STAT,
    input wire logic [15:0] SPEED_REF,
    input wire logic [15:0] ZERO_SPEED_LEVEL,
    input wire logic [15:0] OUT_CURRENT,
    input wire logic FAULT_CLEAR,
    input wire logic FAULT,
    input wire logic ALARM,
    input wire mfid_pkg::mfid_stop_e STOP_MODE,
    input wire logic OUTPUT_CUTOFF,
    input wire mfid_pkg::mfid_ctl_s CTL,
    input wire mfid_pkg::mfid_srch_s SRCH
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------
    // Baseblock length, counted so a short or stuck wait shows
    // ------------
    int unsigned bb_cnt_r;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bb_cnt_r <= 0;
        end else begin
            bb_cnt_r <= SRCH.baseblock ? bb_cnt_r + 1 : 0;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_current_low;
        SRCH.lower_freq && OUT_CURRENT < `MFID_SRCH_CUR_LVL;
    endsequence
    sequence s_search_live;
        DRV_STAT.run_cmd && !OUTPUT_CUTOFF;
    endsequence
    a_cutoff_coast: assert property (
        OUTPUT_CUTOFF |-> FAULT && STOP_MODE == MFID_STOP_COAST)
        else $error("Cutoff without coast fault");
    a_fault_mode: assert property (
        FAULT |-> STOP_MODE != MFID_STOP_NONE)
        else $error("Fault without stop mode");
    a_fault_held: assert property (
        FAULT && !FAULT_CLEAR |=> FAULT)
        else $error("Fault dropped without clear");
    a_brake_idle: assert property (
        CTL.dc_brake |-> !$past(DRV_STAT.run_cmd) && !$past(DRV_STAT.jog_cmd))
        else $error("Brake while commanded to run");
    a_excite_flux: assert property (
        CTL.init_excite |-> $past(DRV_STAT.flux_vector) && !CTL.dc_brake)
        else $error("Excitation outside flux vector");
    a_run_cancels: assert property (
        $rose(DRV_STAT.run_cmd) |=> !CTL.dc_brake && !CTL.init_excite)
        else $error("Run did not cancel braking");
    a_bb_trigger: assert property (
        $rose(SRCH.baseblock) |->
            $past(DRV_STAT.run_cmd) && !$past(DRV_STAT.run_cmd, 2))
        else $error("Search started without run edge");
    a_bb_length: assert property (
        $rose(SRCH.lower_freq) |-> bb_cnt_r == MIN_BB_CYCLES)
        else $error("Baseblock length wrong");
    a_bb_bound: assert property (
        SRCH.baseblock |-> bb_cnt_r < MIN_BB_CYCLES)
        else $error("Baseblock too long");
    a_search_found: assert property (
        s_current_low ##0 s_search_live |=> SRCH.accel_ref && !SRCH.lower_freq)
        else $error("Low current did not end search");
    a_accel_done: assert property (
        SRCH.accel_ref && DRV_STAT.ref_reached |=> !SRCH.accel_ref)
        else $error("Acceleration did not end");
    a_search_abort: assert property (
        !DRV_STAT.run_cmd |=> !SRCH.baseblock && !SRCH.lower_freq)
        else $error("Search kept without run");
endmodule : mfid_checker

bind mfid_top mfid_checker #(.MIN_BB_CYCLES(MIN_BB_CYCLES)) u_mfid_checker (
    .CLK(CLK), .RST(RST), .MF_IN(MF_IN), .MF_FUNC(MF_FUNC),
    .DRV_STAT(DRV_STAT), .SPEED_REF(SPEED_REF),
    .ZERO_SPEED_LEVEL(ZERO_SPEED_LEVEL), .OUT_CURRENT(OUT_CURRENT),
    .FAULT_CLEAR(FAULT_CLEAR), .FAULT(FAULT), .ALARM(ALARM),
    .STOP_MODE(STOP_MODE), .OUTPUT_CUTOFF(OUTPUT_CUTOFF), .CTL(CTL),
    .SRCH(SRCH));

// ==== test/mfid_periph.sv ====
// Model of the run sequencer and motor current beside the decoder
module mfid_periph
    import mfid_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run_cmd,
    input wire logic jog_cmd,
    input wire logic flux,
    input wire logic slow,
    input wire logic cutoff,
    input wire mfid_pkg::mfid_srch_s srch,
    output mfid_pkg::mfid_drv_s drv,
    output logic [15:0] cur
);
    timeunit 1ns;
    timeprecision 1ns;
    logic run_r;
    logic [3:0] acc_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_r <= 1'b0;
            cur <= 16'h0800;
            acc_r <= 4'h0;
        end else begin
            // A cut-off output stops the motor being driven
            run_r <= (run_cmd || jog_cmd) && !cutoff;
            // Slow mode keeps the current high longer
            cur <= srch.lower_freq ? cur - (slow ? 16'h0040 : 16'h0200)
                : 16'h0800;
            acc_r <= srch.accel_ref ? acc_r + 4'h1 : 4'h0;
        end
    end
    assign drv = '{run_r, run_cmd, jog_cmd, flux, acc_r == 4'h3};
endmodule : mfid_periph

// ==== test/mfid_top_tb.sv ====
// Self-checking bench for the multi-function input decoder
module mfid_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mfid_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] mf_in = 8'h00;
    logic [63:0] mf_func = 64'h0;
    logic run_cmd = 1'b0;
    logic jog_cmd = 1'b0;
    logic flux = 1'b0;
    logic slow = 1'b0;
    logic fault_clear = 1'b0;
    logic [15:0] sref = 16'h0000;
    logic [15:0] zsl = 16'h0000;
    logic fault, alarm, cutoff;
    mfid_stop_e stop_mode;
    mfid_ctl_s ctl;
    mfid_srch_s srch;
    mfid_drv_s drv;
    logic [15:0] cur;
    logic [7:0] ctl_codes [4] = '{8'h60, 8'h71, 8'h72, 8'h77};
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 32'hcd44ca99;
    int cyc = 0;
    always #25 clk = ~clk;
    mfid_top #(.MIN_BB_CYCLES(8)) u_mfid_top (.CLK(clk), .RST(rst),
        .MF_IN(mf_in), .MF_FUNC(mf_func), .DRV_STAT(drv), .SPEED_REF(sref),
        .ZERO_SPEED_LEVEL(zsl), .OUT_CURRENT(cur), .FAULT_CLEAR(fault_clear),
        .FAULT(fault), .ALARM(alarm), .STOP_MODE(stop_mode),
        .OUTPUT_CUTOFF(cutoff), .CTL(ctl), .SRCH(srch));
    mfid_periph u_mfid_periph (.clk(clk), .rst(rst), .run_cmd(run_cmd),
        .jog_cmd(jog_cmd), .flux(flux), .slow(slow), .cutoff(cutoff),
        .srch(srch), .drv(drv), .cur(cur));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic chk(input string nm, input logic [4:0] e, logic [4:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic summarize();
        $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    // One input only carries a function, as configuration demands
    task automatic set_code(input int k, input logic [7:0] code);
        mf_func = 64'h0;
        mf_func[8*k +: 8] = code;
    endtask : set_code
    function automatic logic [4:0] exp_fault(input logic [7:0] code);
        case (code[3:2])
            2'd0: return {3'b100, MFID_STOP_DECEL};
            2'd1: return {3'b101, MFID_STOP_COAST};
            2'd2: return {3'b100, MFID_STOP_FAST};
            default: return {3'b010, MFID_STOP_NONE};
        endcase
    endfunction : exp_fault
    function automatic logic [4:0] exp_ctl(logic [7:0] c, logic r, f, z);
        return {c == 8'h60 && !r && !f, c == 8'h60 && !r && f, c == 8'h71,
            c == 8'h72 && z, c == 8'h77};
    endfunction : exp_ctl
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin : main
        logic [7:0] code;
        int k;
        step(16);
        rst = 1'b0;
        for (int c = 32; c < 48; c++) begin
            code = c[7:0];
            k = $unsigned($random(seed)) % 8;
            // Settle the input before its code is set, so a stale level
            // is never decoded as a fault and held
            mf_func = 64'h0;
            mf_in[k] = code[0];
            step(6);
            set_code(k, code);
            run_cmd = 1'($random(seed));
            step(6);
            if (code[1]) begin
                run_cmd = 1'b0;
                mf_in[k] = ~code[0];
                step(6);
                chk("idle_mask", 5'h00, {fault, alarm, cutoff, stop_mode});
                run_cmd = 1'b1;
            end
            mf_in[k] = ~code[0];
            step(6);
            chk("ext_fault", exp_fault(code), {fault, alarm, cutoff, stop_mode});
            mf_in[k] = code[0];
            run_cmd = 1'b0;
            step(6);
            fault_clear = 1'b1;
            step(1);
            fault_clear = 1'b0;
            step(1);
            chk("cleared", 5'h00, {fault, alarm, cutoff, stop_mode});
        end
        $display("External fault codes done");
        for (int i = 0; i < 16; i++) begin
            code = ctl_codes[i % 4];
            k = $unsigned($random(seed)) % 8;
            set_code(k, code);
            {run_cmd, jog_cmd, flux} = 3'($random(seed));
            sref = 16'($random(seed));
            zsl = sref + 16'($unsigned($random(seed)) % 2);
            mf_in[k] = 1'b1;
            step(6);
            chk("ctl_on", exp_ctl(code, run_cmd | jog_cmd, flux, sref < zsl), ctl);
            run_cmd = 1'b1;
            step(2);
            chk("ctl_run", exp_ctl(code, 1'b1, flux, sref < zsl), ctl);
            mf_in[k] = 1'b0;
            step(6);
            chk("ctl_off", 5'h00, ctl);
        end
        $display("Control selects done");
        run_cmd = 1'b0;
        jog_cmd = 1'b0;
        flux = 1'b0;
        for (int j = 0; j < 4; j++) begin
            code = j[0] ? 8'h62 : 8'h61;
            slow = j[1];
            k = $unsigned($random(seed)) % 8;
            set_code(k, code);
            mf_in[k] = 1'b1;
            step(6);
            run_cmd = 1'b1;
            step(1);
            chk("srch_start", {2'b01, code == 8'h61, 2'b00}, {1'b0, srch});
            if (j == 3) begin
                step(3);
                run_cmd = 1'b0;
                step(2);
                chk("srch_abort", 5'h00, {1'b0, srch});
            end else begin
                for (int w = 0; w < 60 && !srch.accel_ref; w++) begin
                    step(1);
                end
                chk("srch_accel", {2'b00, code == 8'h61, 2'b01}, {1'b0, srch});
                for (int w = 0; w < 20 && srch.accel_ref; w++) begin
                    step(1);
                end
                chk("srch_done", {2'b00, code == 8'h61, 2'b00}, {1'b0, srch});
            end
            run_cmd = 1'b0;
            mf_in[k] = 1'b0;
            step(4);
        end
        $display("Speed search done");
        summarize();
    end
endmodule : mfid_top_tb
